// [design/rkc_top.sv]
`timescale 1ns/1ps

// What this block does
// - With the calibration enable bit 7 set, the selected calibration frequency drives the pin.
// - Bits 6:5 pick 1 Hz, 512 Hz, 500 Hz or 16.384 kHz output with its window.
// - Bits 3:1 pick GPIO, alternate control or an interrupt input gated by the top bit.
// - Bit 0 enables the first external interrupt input.
// - Time counters advance in the 32.768 kHz tick domain.
// - Clock-config and alarm-period writes reach the clock logic within two 128 Hz cycles.
// - Counters never stop for reads; reads see live values.
// - Hundredths wrap 127 to 0 into seconds; seconds and minutes wrap at 59.
// - Hours wrap at 23 in 24-hour mode or 255 otherwise, setting the midnight flag.
// - Time counters clear only on power-on reset.
module rkc_top #(
   parameter int CAL500_HALF = rkc_pkg::CAL500_HALF
) (
   // Clock, resets, enable
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              por_n_i,
   input  wire logic              ce_i,
   // 32.768 kHz tick, one clk wide
   input  wire logic              rtc_tick_i,
   // Register port
   input  rkc_pkg::rkc_sfr_req_t  sfr_req_i,
   output logic [7:0]             sfr_rdata_o,
   // External interrupt pins
   input  wire logic              ext_irq_a_pin_i,
   input  wire logic              ext_irq_b_pin_i,
   output logic                   ext_irq_a_o,
   output logic                   ext_irq_b_o,
   output logic                   alt_control_input_o,
   output logic                   ext_irq_b_gpio_o,
   // Calibration output pin
   output logic                   cal_output_pin_o,
   output logic                   cal_output_oe_n_o,
   // Values seen by the clock logic
   output logic [7:0]             clock_config_o,
   output logic [7:0]             alarm_period_o,
   output logic [7:0]             power_control_reg_o,
   output logic                   rtc_irq_pending_o
);

   rkc_pkg::rkc_time_t  time_w;
   logic                tick128;
   logic                midnight;
   logic [3:0]          ld;

   logic [7:0]  key_q, key_d;
   logic [7:0]  pin_q, pin_d;
   logic [7:0]  cfg_q, cfg_d;
   logic [7:0]  per_q, per_d;
   logic [7:0]  pwr_q, pwr_d;
   logic [7:0]  cfg_eff_q, cfg_eff_d;
   logic [7:0]  per_eff_q, per_eff_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        pend_q, pend_d;

   logic                        [rkc_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
   logic [31:0]                 div_q, div_d;
   logic                        sq500_q, sq500_d;
   logic                        cal_q, cal_d;
   logic                        irq_a_q, irq_a_d;
   logic                        irq_b_q, irq_b_d;
   logic                        alt_q, alt_d;
   logic                        gpio_q, gpio_d;

   logic        wr_time_ok, wr_pwr_ok, time_addr, accepted;
   logic [2:0]  b_func;

   // ---------------------------------------------------------------
   // Key protection
   // ---------------------------------------------------------------
   assign time_addr  = sfr_req_i.addr inside {rkc_pkg::ADDR_FRAC, rkc_pkg::ADDR_SEC,
                                              rkc_pkg::ADDR_MIN, rkc_pkg::ADDR_HOUR,
                                              rkc_pkg::ADDR_PIN_CONFIG};
   assign wr_time_ok = sfr_req_i.wr && time_addr && (key_q == rkc_pkg::KEY_TIME);
   assign wr_pwr_ok  = sfr_req_i.wr && (sfr_req_i.addr == rkc_pkg::ADDR_POWER_CONTROL)
                       && (key_q == rkc_pkg::KEY_POWER);
   assign accepted   = wr_time_ok || wr_pwr_ok;

   assign ld[0] = wr_time_ok && (sfr_req_i.addr == rkc_pkg::ADDR_FRAC);
   assign ld[1] = wr_time_ok && (sfr_req_i.addr == rkc_pkg::ADDR_SEC);
   assign ld[2] = wr_time_ok && (sfr_req_i.addr == rkc_pkg::ADDR_MIN);
   assign ld[3] = wr_time_ok && (sfr_req_i.addr == rkc_pkg::ADDR_HOUR);

   rkc_time u_time (
      .clk_i      (clk_i),
      .por_n_i    (por_n_i),
      .ce_i       (ce_i),
      .tick_i     (rtc_tick_i),
      .day24_i    (cfg_eff_q[rkc_pkg::CFG_DAY24]),
      .ld_i       (ld),
      .ld_data_i  (sfr_req_i.wdata),
      .time_o     (time_w),
      .tick128_o  (tick128),
      .midnight_o (midnight)
   );

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   always_comb
   begin
      key_d     = key_q;
      pin_d     = pin_q;
      cfg_d     = cfg_q;
      per_d     = per_q;
      pwr_d     = pwr_q;
      cfg_eff_d = cfg_eff_q;
      per_eff_d = per_eff_q;
      rdata_d   = rdata_q;
      pend_d    = pend_q;
      if (sfr_req_i.wr) begin
         case (sfr_req_i.addr)
            rkc_pkg::ADDR_UNLOCK_KEY:   key_d = sfr_req_i.wdata;
            rkc_pkg::ADDR_CLOCK_CONFIG: cfg_d = sfr_req_i.wdata;
            rkc_pkg::ADDR_ALARM_PERIOD: per_d = sfr_req_i.wdata;
            default:                    key_d = key_q;
         endcase
      end
      if (wr_time_ok && (sfr_req_i.addr == rkc_pkg::ADDR_PIN_CONFIG))
         pin_d = sfr_req_i.wdata;
      if (wr_pwr_ok)
         pwr_d = sfr_req_i.wdata;
      if (accepted)
         key_d = rkc_pkg::KEY_LOCKED;
      // Midnight flag: a hardware set beats a same-cycle software clear
      if (midnight) begin
         cfg_d[rkc_pkg::CFG_MIDNIGHT] = 1'b1;
         pend_d                       = 1'b1;
      end
      else if (sfr_req_i.wr && (sfr_req_i.addr == rkc_pkg::ADDR_CLOCK_CONFIG)
               && !sfr_req_i.wdata[rkc_pkg::CFG_MIDNIGHT])
         pend_d = 1'b0;
      // Clock logic samples config once per 128 Hz tick: worst case under two periods
      if (tick128) begin
         cfg_eff_d = cfg_q;
         per_eff_d = per_q;
      end
      if (sfr_req_i.rd) begin
         case (sfr_req_i.addr)
            rkc_pkg::ADDR_CLOCK_CONFIG:  rdata_d = cfg_q;
            rkc_pkg::ADDR_FRAC:          rdata_d = time_w.frac;
            rkc_pkg::ADDR_SEC:           rdata_d = time_w.sec;
            rkc_pkg::ADDR_MIN:           rdata_d = time_w.min;
            rkc_pkg::ADDR_HOUR:          rdata_d = time_w.hour;
            rkc_pkg::ADDR_ALARM_PERIOD:  rdata_d = per_q;
            rkc_pkg::ADDR_UNLOCK_KEY:    rdata_d = key_q;
            rkc_pkg::ADDR_POWER_CONTROL: rdata_d = pwr_q;
            rkc_pkg::ADDR_PIN_CONFIG:    rdata_d = pin_q & 8'hEF;
            default:                     rdata_d = rkc_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i) begin
         key_q     <= rkc_pkg::KEY_LOCKED;
         pin_q     <= rkc_pkg::RST_BYTE;
         cfg_q     <= rkc_pkg::RST_BYTE;
         per_q     <= rkc_pkg::RST_BYTE;
         pwr_q     <= rkc_pkg::RST_BYTE;
         cfg_eff_q <= rkc_pkg::RST_BYTE;
         per_eff_q <= rkc_pkg::RST_BYTE;
         rdata_q   <= rkc_pkg::RST_BYTE;
         pend_q    <= 1'b0;
      end
      else if (ce_i) begin
         key_q     <= key_d;
         pin_q     <= pin_d;
         cfg_q     <= cfg_d;
         per_q     <= per_d;
         pwr_q     <= pwr_d;
         cfg_eff_q <= cfg_eff_d;
         per_eff_q <= per_eff_d;
         rdata_q   <= rdata_d;
         pend_q    <= pend_d;
      end
   end

   // ---------------------------------------------------------------
   // Calibration output and pin functions
   // ---------------------------------------------------------------
   assign b_func = pin_q[rkc_pkg::PIN_B_FUNC_HI:rkc_pkg::PIN_B_FUNC_LO];

   always_comb
   begin
      tick_cnt_d = rtc_tick_i ? tick_cnt_q + 1'b1 : tick_cnt_q;
      // 500 Hz does not divide the tick, so it comes from the core clock
      div_d      = div_q + 32'd1;
      sq500_d    = sq500_q;
      if (div_q >= 32'(CAL500_HALF - 1)) begin
         div_d   = '0;
         sq500_d = !sq500_q;
      end
      case (rkc_pkg::rkc_fsel_t'(pin_q[rkc_pkg::PIN_FSEL_HI:rkc_pkg::PIN_FSEL_LO]))
         rkc_pkg::FSEL_1HZ:   cal_d = tick_cnt_q[rkc_pkg::TAP_1HZ];
         rkc_pkg::FSEL_512HZ: cal_d = tick_cnt_q[rkc_pkg::TAP_512HZ];
         rkc_pkg::FSEL_500HZ: cal_d = sq500_q;
         rkc_pkg::FSEL_16KHZ: cal_d = tick_cnt_q[rkc_pkg::TAP_16KHZ];
         default:             cal_d = 1'b0;
      endcase
      cal_d   = cal_d && pin_q[rkc_pkg::PIN_CAL_EN];
      irq_a_d = ext_irq_a_pin_i && pin_q[rkc_pkg::PIN_A_EN];
      irq_b_d = ext_irq_b_pin_i && b_func[rkc_pkg::B_FUNC_IRQ_MODE]
                && b_func[rkc_pkg::B_FUNC_IRQ_EN];
      alt_d   = ext_irq_b_pin_i && !b_func[rkc_pkg::B_FUNC_IRQ_MODE]
                && b_func[rkc_pkg::B_FUNC_ALT];
      gpio_d  = !b_func[rkc_pkg::B_FUNC_IRQ_MODE] && !b_func[rkc_pkg::B_FUNC_ALT];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i) begin
         tick_cnt_q <= '0;
         div_q      <= '0;
         sq500_q    <= 1'b0;
         cal_q      <= 1'b0;
         irq_a_q    <= 1'b0;
         irq_b_q    <= 1'b0;
         alt_q      <= 1'b0;
         gpio_q     <= 1'b1;
      end
      else if (ce_i) begin
         tick_cnt_q <= tick_cnt_d;
         div_q      <= div_d;
         sq500_q    <= sq500_d;
         cal_q      <= cal_d;
         irq_a_q    <= irq_a_d;
         irq_b_q    <= irq_b_d;
         alt_q      <= alt_d;
         gpio_q     <= gpio_d;
      end
   end

   assign cal_output_pin_o    = cal_q;
   assign cal_output_oe_n_o   = !pin_q[rkc_pkg::PIN_CAL_EN];
   assign ext_irq_a_o         = irq_a_q;
   assign ext_irq_b_o         = irq_b_q;
   assign alt_control_input_o = alt_q;
   assign ext_irq_b_gpio_o    = gpio_q;
   assign sfr_rdata_o         = rdata_q;
   assign clock_config_o      = cfg_eff_q;
   assign alarm_period_o      = per_eff_q;
   assign power_control_reg_o = pwr_q;
   assign rtc_irq_pending_o   = pend_q;

endmodule : rkc_top

// [design/rkc_pkg.sv]
package rkc_pkg;

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CLOCK_CONFIG  = 8'hA1;
   localparam logic [7:0] ADDR_FRAC          = 8'hA2;
   localparam logic [7:0] ADDR_SEC           = 8'hA3;
   localparam logic [7:0] ADDR_MIN           = 8'hA4;
   localparam logic [7:0] ADDR_HOUR          = 8'hA5;
   localparam logic [7:0] ADDR_ALARM_PERIOD  = 8'hA6;
   localparam logic [7:0] ADDR_UNLOCK_KEY    = 8'hC1;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'hC5;
   localparam logic [7:0] ADDR_PIN_CONFIG    = 8'hFF;

   // ---------------------------------------------------------------
   // Keys and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] KEY_POWER  = 8'hA7;
   localparam logic [7:0] KEY_TIME   = 8'hEA;
   localparam logic [7:0] KEY_LOCKED = 8'h00;
   localparam logic [7:0] RST_BYTE   = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int PIN_CAL_EN      = 7;
   localparam int PIN_FSEL_HI     = 6;
   localparam int PIN_FSEL_LO     = 5;
   localparam int PIN_B_FUNC_HI   = 3;
   localparam int PIN_B_FUNC_LO   = 1;
   localparam int PIN_A_EN        = 0;
   localparam int CFG_DAY24       = 6;
   localparam int CFG_MIDNIGHT    = 0;
   localparam int B_FUNC_IRQ_EN   = 2;
   localparam int B_FUNC_IRQ_MODE = 1;
   localparam int B_FUNC_ALT      = 0;

   // ---------------------------------------------------------------
   // Counter limits and tick divisions
   // ---------------------------------------------------------------
   localparam logic [7:0] FRAC_MAX   = 8'h7F;
   localparam logic [7:0] SEXA_MAX   = 8'h3B;
   localparam logic [7:0] HOUR24_MAX = 8'h17;
   localparam logic [7:0] HOUR_MAX   = 8'hFF;
   localparam logic [7:0] PRE_MAX    = 8'hFF;
   localparam int         TICK_W     = 15;
   localparam int         TAP_1HZ    = 14;
   localparam int         TAP_512HZ  = 5;
   localparam int         TAP_16KHZ  = 0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ       = 40_000_000;
   localparam int CAL500_HZ    = 500;
   localparam int CAL500_HALF  = CLK_HZ / (2 * CAL500_HZ);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FSEL_1HZ,
      FSEL_512HZ,
      FSEL_500HZ,
      FSEL_16KHZ
   } rkc_fsel_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rkc_sfr_req_t;

   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] frac;
   } rkc_time_t;

endpackage : rkc_pkg

// [design/rkc_time.sv]
`timescale 1ns/1ps

module rkc_time (
   // Clock, power-on reset, enable
   input  wire logic              clk_i,
   input  wire logic              por_n_i,
   input  wire logic              ce_i,
   // 32.768 kHz tick and mode
   input  wire logic              tick_i,
   input  wire logic              day24_i,
   // Loads: one strobe per field, hour/min/sec/frac order
   input  wire logic [3:0]        ld_i,
   input  wire logic [7:0]        ld_data_i,
   // Outputs
   output rkc_pkg::rkc_time_t     time_o,
   output logic                   tick128_o,
   output logic                   midnight_o
);

   rkc_pkg::rkc_time_t time_q, time_d;
   logic [7:0]         pre_q, pre_d;
   logic               mid_q, mid_d;
   logic [7:0]         lim   [4];
   logic [3:0]         carry;
   logic [3:0]         wrap;
   logic [7:0]         cur   [4];
   logic [7:0]         nxt   [4];

   assign lim[0] = rkc_pkg::FRAC_MAX;
   assign lim[1] = rkc_pkg::SEXA_MAX;
   assign lim[2] = rkc_pkg::SEXA_MAX;
   assign lim[3] = day24_i ? rkc_pkg::HOUR24_MAX : rkc_pkg::HOUR_MAX;
   assign cur[0] = time_q.frac;
   assign cur[1] = time_q.sec;
   assign cur[2] = time_q.min;
   assign cur[3] = time_q.hour;
   assign carry[0] = tick_i && (pre_q == rkc_pkg::PRE_MAX);

   // ---------------------------------------------------------------
   // Ripple chain: each stage wraps at its limit; all but the hour stage carry on
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_stage
      assign wrap[g] = carry[g] && (cur[g] >= lim[g]);
      if (g < 3) begin : g_carry
         assign carry[g+1] = wrap[g];
      end
      always_comb
      begin
         nxt[g] = cur[g];
         if (ld_i[g])
            nxt[g] = ld_data_i;
         else if (wrap[g])
            nxt[g] = rkc_pkg::RST_BYTE;
         else if (carry[g])
            nxt[g] = cur[g] + 8'h01;
      end
   end

   always_comb
   begin
      pre_d       = tick_i ? pre_q + 8'h01 : pre_q;
      time_d.frac = nxt[0];
      time_d.sec  = nxt[1];
      time_d.min  = nxt[2];
      time_d.hour = nxt[3];
      mid_d       = wrap[3] && !ld_i[3];
   end

   // Only power-on reset clears time; other resets leave it running
   always_ff @(posedge clk_i)
   begin
      if (!por_n_i) begin
         time_q <= '0;
         pre_q  <= rkc_pkg::RST_BYTE;
         mid_q  <= 1'b0;
      end
      else if (ce_i) begin
         time_q <= time_d;
         pre_q  <= pre_d;
         mid_q  <= mid_d;
      end
   end

   assign time_o     = time_q;
   assign tick128_o  = ce_i && carry[0];
   assign midnight_o = mid_q;

endmodule : rkc_time

// [sim/rkc_top_monitor.sv]
`timescale 1ns/1ps

module rkc_top_monitor (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   input  wire logic             ce_i,
   // Register port
   input  rkc_pkg::rkc_sfr_req_t sfr_req_i,
   input  wire logic [7:0]       sfr_rdata_o,
   // Pins
   input  wire logic             ext_irq_a_pin_i,
   input  wire logic             ext_irq_b_pin_i,
   input  wire logic             ext_irq_a_o,
   input  wire logic             ext_irq_b_o,
   input  wire logic             alt_control_input_o,
   input  wire logic             ext_irq_b_gpio_o,
   input  wire logic             cal_output_pin_o,
   input  wire logic             cal_output_oe_n_o,
   // Applied values
   input  wire logic [7:0]       clock_config_o,
   input  wire logic [7:0]       alarm_period_o,
   input  wire logic [7:0]       power_control_reg_o
);
   // ---------------------------------------------------------------
   // Shadow of key, pin config and last config writes
   // ---------------------------------------------------------------
   logic [7:0] key_q, key_d, pin_q, pin_d, cfg_q, cfg_d, alm_q, alm_d, wdat;
   logic       wr_go, rd_go, exp_a;
   logic [2:0] exp_b;

   assign wr_go = ce_i & sfr_req_i.wr;
   assign rd_go = ce_i & sfr_req_i.rd;
   assign wdat  = sfr_req_i.wdata;
   assign exp_a = ext_irq_a_pin_i & pin_q[0];
   assign exp_b = {ext_irq_b_pin_i & pin_q[3] & pin_q[2],
                   ext_irq_b_pin_i & ~pin_q[2] & pin_q[1], ~pin_q[2] & ~pin_q[1]};

   always_comb
   begin
      key_d = key_q;
      pin_d = pin_q;
      cfg_d = cfg_q;
      alm_d = alm_q;
      if (wr_go)
      begin
         case (sfr_req_i.addr)
            rkc_pkg::ADDR_UNLOCK_KEY:   key_d = wdat;
            rkc_pkg::ADDR_CLOCK_CONFIG: cfg_d = wdat;
            rkc_pkg::ADDR_ALARM_PERIOD: alm_d = wdat;
            rkc_pkg::ADDR_POWER_CONTROL:
               if (key_q == rkc_pkg::KEY_POWER) key_d = rkc_pkg::KEY_LOCKED;
            rkc_pkg::ADDR_PIN_CONFIG:
               if (key_q == rkc_pkg::KEY_TIME)
               begin
                  pin_d = wdat;
                  key_d = rkc_pkg::KEY_LOCKED;
               end
            rkc_pkg::ADDR_FRAC, rkc_pkg::ADDR_SEC, rkc_pkg::ADDR_MIN, rkc_pkg::ADDR_HOUR:
               if (key_q == rkc_pkg::KEY_TIME) key_d = rkc_pkg::KEY_LOCKED;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         key_q <= 8'h00;
         pin_q <= 8'h00;
         cfg_q <= 8'h00;
         alm_q <= 8'h00;
      end
      else
      begin
         key_q <= key_d;
         pin_q <= pin_d;
         cfg_q <= cfg_d;
         alm_q <= alm_d;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   AST_CAL_OE: assert property (cal_output_oe_n_o == ~pin_q[7])
      else $error("calibration pin enable differs from config bit 7");
   AST_CAL_OFF: assert property ((ce_i && !pin_q[7]) |=> !cal_output_pin_o)
      else $error("calibration pin active while disabled");
   AST_PIN_A: assert property (ce_i |=> ext_irq_a_o == $past(exp_a))
      else $error("first interrupt input wrong");
   AST_PIN_B: assert property (
      ce_i |=> {ext_irq_b_o, alt_control_input_o, ext_irq_b_gpio_o} == $past(exp_b))
      else $error("second interrupt pin function wrong");
   AST_PWR_KEEP: assert property (
      (wr_go && sfr_req_i.addr == rkc_pkg::ADDR_POWER_CONTROL && key_q != rkc_pkg::KEY_POWER)
      |=> $stable(power_control_reg_o)) else $error("locked power write accepted");
   AST_PWR_TAKE: assert property (
      (wr_go && sfr_req_i.addr == rkc_pkg::ADDR_POWER_CONTROL && key_q == rkc_pkg::KEY_POWER)
      |=> power_control_reg_o == $past(wdat)) else $error("unlocked power write lost");
   AST_KEY_READ: assert property (
      (rd_go && sfr_req_i.addr == rkc_pkg::ADDR_UNLOCK_KEY) |=> sfr_rdata_o == $past(key_q))
      else $error("key register value wrong");
   AST_CFG_APPLY: assert property (
      (wr_go && sfr_req_i.addr == rkc_pkg::ADDR_CLOCK_CONFIG) |=> ##[0:520]
      clock_config_o == cfg_q) else $error("clock config not applied in time");
   AST_ALM_APPLY: assert property (
      (wr_go && sfr_req_i.addr == rkc_pkg::ADDR_ALARM_PERIOD) |=> ##[0:520]
      alarm_period_o == alm_q) else $error("alarm period not applied in time");
endmodule : rkc_top_monitor

bind rkc_top rkc_top_monitor u_mon (.clk_i, .rstn_i, .ce_i, .sfr_req_i, .sfr_rdata_o,
   .ext_irq_a_pin_i, .ext_irq_b_pin_i, .ext_irq_a_o, .ext_irq_b_o, .alt_control_input_o,
   .ext_irq_b_gpio_o, .cal_output_pin_o, .cal_output_oe_n_o, .clock_config_o,
   .alarm_period_o, .power_control_reg_o);

// [sim/rkc_top_tb.sv]
`timescale 1ns/1ps

module rkc_top_tb;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfg;
      logic       pa;
      logic       pb;
      logic [4:0] exp;  // a, b, alt, gpio, oe_n
      logic [7:0] tog;  // Calibration pin edges in 128 cycles
   } rkc_row_t;

   logic clk_i = 1'b0, rstn_i = 1'b0, por_n_i = 1'b0, ce_i = 1'b1, tick = 1'b1;
   logic pa = 1'b0, pb = 1'b0, ia, ib, alt, gpio, cal, oe_n, pend, prev;
   logic [7:0] rdata, cfg_o, alm_o, pwr_o, d, e, v;
   rkc_pkg::rkc_sfr_req_t req = '0;
   rkc_pkg::rkc_time_t    t;
   int n, n_errors = 0, n_compared = 0, cycles = 0;
   rkc_row_t rows [12] = '{
      '{8'h00, 1'h1, 1'h1, 5'h03, 8'h00}, '{8'h01, 1'h1, 1'h0, 5'h13, 8'h00},
      '{8'h03, 1'h0, 1'h1, 5'h05, 8'h00}, '{8'h04, 1'h1, 1'h1, 5'h01, 8'h00},
      '{8'h0D, 1'h1, 1'h1, 5'h19, 8'h00}, '{8'h0B, 1'h0, 1'h1, 5'h05, 8'h00},
      '{8'h18, 1'h1, 1'h1, 5'h03, 8'h00}, '{8'h0E, 1'h1, 1'h0, 5'h01, 8'h00},
      '{8'h80, 1'h0, 1'h0, 5'h02, 8'h00}, '{8'hA0, 1'h0, 1'h0, 5'h02, 8'h04},
      '{8'hC0, 1'h0, 1'h0, 5'h02, 8'h20}, '{8'hE0, 1'h0, 1'h0, 5'h02, 8'h80}};

   always #12.5 clk_i = ~clk_i;

   rkc_top #(.CAL500_HALF(4)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i),
      .ce_i(ce_i), .rtc_tick_i(tick), .sfr_req_i(req), .sfr_rdata_o(rdata),
      .ext_irq_a_pin_i(pa), .ext_irq_b_pin_i(pb), .ext_irq_a_o(ia), .ext_irq_b_o(ib),
      .alt_control_input_o(alt), .ext_irq_b_gpio_o(gpio), .cal_output_pin_o(cal),
      .cal_output_oe_n_o(oe_n), .clock_config_o(cfg_o), .alarm_period_o(alm_o),
      .power_control_reg_o(pwr_o), .rtc_irq_pending_o(pend));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #2;
   endtask : cyc

   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
      cyc(1);
      req = '{wr: w, rd: ~w, addr: a, wdata: wd};
      cyc(1);
      req = '0;
   endtask : acc

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      acc(1'b1, a, wd);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      acc(1'b0, a, 8'h00);
      q = rdata;
   endtask : rd

   task automatic kwr(input logic [7:0] a, input logic [7:0] wd);
      wr(rkc_pkg::ADDR_UNLOCK_KEY, rkc_pkg::KEY_TIME);
      wr(a, wd);
   endtask : kwr

   task automatic rtime(output rkc_pkg::rkc_time_t tm);
      logic [7:0] again;
      do
      begin
         rd(rkc_pkg::ADDR_FRAC, tm.frac);
         rd(rkc_pkg::ADDR_SEC, tm.sec);
         rd(rkc_pkg::ADDR_MIN, tm.min);
         rd(rkc_pkg::ADDR_HOUR, tm.hour);
         rd(rkc_pkg::ADDR_FRAC, again);
      end while (again !== tm.frac);
   endtask : rtime

   // Hang guard, far above the few thousand cycles the tests need
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         $display("wrong value at %0t: run too long", $time);
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      cyc(10);
      rstn_i = 1'b1;
      por_n_i = 1'b1;
      foreach (rows[i])
      begin
         kwr(rkc_pkg::ADDR_PIN_CONFIG, rows[i].cfg);
         pa = rows[i].pa;
         pb = rows[i].pb;
         cyc(2);
         chk({ia, ib, alt, gpio, oe_n}, rows[i].exp, "pins");
         rd(rkc_pkg::ADDR_PIN_CONFIG, d);
         chk(d, rows[i].cfg & 8'hEF, "pin config readback");
         n = 0;
         for (int c = 0; c < 128; c++)
         begin
            prev = cal;
            cyc(1);
            if (cal !== prev) n++;
         end
         chk(n > rows[i].tog + 1 || n + 1 < rows[i].tog, 0, "calibration edges");
         if (!rows[i].cfg[7]) chk(cal, 0, "calibration idle");
      end
      $display("test pin table done");
      wr(rkc_pkg::ADDR_POWER_CONTROL, 8'h55);
      chk(pwr_o, 8'h00, "power without key");
      wr(rkc_pkg::ADDR_UNLOCK_KEY, rkc_pkg::KEY_POWER);
      wr(rkc_pkg::ADDR_POWER_CONTROL, 8'h5A);
      chk(pwr_o, 8'h5A, "power with key");
      rd(rkc_pkg::ADDR_UNLOCK_KEY, d);
      chk(d, 8'h00, "key relocked");
      wr(rkc_pkg::ADDR_POWER_CONTROL, 8'hA5);
      chk(pwr_o, 8'h5A, "second power write");
      kwr(rkc_pkg::ADDR_POWER_CONTROL, 8'hA5);
      chk(pwr_o, 8'h5A, "power with time key");
      kwr(rkc_pkg::ADDR_SEC, 8'h1E);
      wr(rkc_pkg::ADDR_SEC, 8'h05);
      wr(rkc_pkg::ADDR_PIN_CONFIG, 8'h00);
      rd(rkc_pkg::ADDR_SEC, d);
      chk(d, 8'h1E, "seconds write");
      chk(oe_n, 0, "pin config locked");
      rd(8'h10, d);
      chk(d, 8'h00, "unmapped read");
      $display("test key done");
      rd(rkc_pkg::ADDR_FRAC, d);
      cyc(300);
      rd(rkc_pkg::ADDR_FRAC, e);
      chk(d === e, 0, "hundredths running");
      rstn_i = 1'b0;
      cyc(2);
      rstn_i = 1'b1;
      rd(rkc_pkg::ADDR_SEC, d);
      chk(d, 8'h1E, "seconds kept");
      chk({pwr_o, oe_n}, 9'h001, "registers reset");
      por_n_i = 1'b0;
      cyc(2);
      por_n_i = 1'b1;
      rd(rkc_pkg::ADDR_SEC, d);
      chk(d, 8'h00, "seconds cleared");
      $display("test reset done");
      rd(rkc_pkg::ADDR_FRAC, d);
      ce_i = 1'b0;
      wr(rkc_pkg::ADDR_UNLOCK_KEY, rkc_pkg::KEY_POWER);
      cyc(600);
      ce_i = 1'b1;
      tick = 1'b0;
      wr(rkc_pkg::ADDR_POWER_CONTROL, 8'h3C);
      chk(pwr_o, 8'h00, "write while frozen");
      cyc(600);
      tick = 1'b1;
      rd(rkc_pkg::ADDR_FRAC, e);
      chk(8'(e - d) > 8'h01, 0, "time frozen");
      $display("test enable done");
      for (int m = 0; m < 3; m++)
      begin
         v = (m == 0) ? 8'h40 : 8'h00;
         wr(rkc_pkg::ADDR_CLOCK_CONFIG, v);
         wr(rkc_pkg::ADDR_ALARM_PERIOD, v ^ 8'h3C);
         n = 0;
         while ((cfg_o !== v || alm_o !== (v ^ 8'h3C)) && n < 520)
         begin
            cyc(1);
            n++;
         end
         chk({cfg_o, alm_o}, {v, v ^ 8'h3C}, "applied values");
         chk(pend, 0, "pending cleared");
         kwr(rkc_pkg::ADDR_HOUR, (m == 1) ? rkc_pkg::HOUR_MAX : rkc_pkg::HOUR24_MAX);
         kwr(rkc_pkg::ADDR_MIN, rkc_pkg::SEXA_MAX);
         kwr(rkc_pkg::ADDR_SEC, rkc_pkg::SEXA_MAX);
         kwr(rkc_pkg::ADDR_FRAC, rkc_pkg::FRAC_MAX);
         wr(rkc_pkg::ADDR_UNLOCK_KEY, rkc_pkg::KEY_LOCKED);
         n = 0;
         do
         begin
            rtime(t);
            n++;
         end while (t.sec !== 8'h00 && n < 40);
         chk(t, {(m == 2) ? 8'h18 : 8'h00, 24'h0}, "time after wrap");
         rd(rkc_pkg::ADDR_CLOCK_CONFIG, d);
         chk({d, pend}, {v | {7'h00, m < 2}, m < 2}, "midnight");
      end
      $display("test wrap done");
      complete_run();
   end
endmodule : rkc_top_tb
